// *** src/fpp_pkg.sv ***
// shared constants and types for the flash programming port
package fpp_pkg;

	// clock and self-timed operation lengths
	localparam int CLK_NS        = 5;
	localparam int ERASE_NS      = 500_000_000;
	localparam int SER_WRITE_NS  = 500_000;
	localparam int PAR_WRITE_NS  = 50_000;
	localparam int ERASE_CYC     = ERASE_NS / CLK_NS;
	localparam int SER_WRITE_CYC = SER_WRITE_NS / CLK_NS;
	localparam int PAR_WRITE_CYC = PAR_WRITE_NS / CLK_NS;
	localparam int TIMER_W       = 27;

	// code array geometry
	localparam int          ADDR_W     = 12;
	localparam logic [12:0] SWEEP_LAST = 13'h0fff;
	localparam logic [7:0]  ERASED     = 8'hff;

	// serial instruction bytes
	localparam logic [7:0] OPC_CTRL       = 8'hac;
	localparam logic [7:0] OPC_ENABLE_2ND = 8'h53;
	localparam logic [7:0] ENABLE_ECHO    = 8'h69;
	localparam logic [7:0] OPC_READ_BYTE  = 8'h20;
	localparam logic [7:0] OPC_WRITE_BYTE = 8'h40;
	localparam logic [7:0] OPC_READ_LOCK  = 8'h24;
	localparam logic [7:0] OPC_READ_SIG   = 8'h28;
	localparam logic [7:0] OPC_READ_PAGE  = 8'h30;
	localparam logic [7:0] OPC_WRITE_PAGE = 8'h50;
	localparam logic [2:0] ERASE_TAG      = 3'h4;
	localparam logic [5:0] LOCK_TAG       = 6'h38;
	localparam logic [7:0] PAGE_LAST      = 8'hff;

	// parallel mode-select patterns, order {a,b,c,d,e}
	localparam logic [4:0] PM_WRITE_CODE = 5'h0f;
	localparam logic [4:0] PM_READ_CODE  = 5'h03;
	localparam logic [4:0] PM_WRITE_LB1  = 5'h1f;
	localparam logic [4:0] PM_WRITE_LB2  = 5'h1c;
	localparam logic [4:0] PM_WRITE_LB3  = 5'h16;
	localparam logic [4:0] PM_READ_LOCK  = 5'h1a;
	localparam logic [4:0] PM_ERASE      = 5'h14;
	localparam logic [4:0] PM_READ_SIG   = 5'h00;

	// lock bits appear on data bits 4:2
	localparam int LOCK_POS = 2;

	// pin synchroniser reset: program strobe idles high (bit 27)
	localparam logic [28:0] PIN_SYNC_RST = 29'h08000000;

	// register map
	localparam logic [11:0] CTRL_OFF   = 12'h000;
	localparam logic [11:0] STATUS_OFF = 12'h004;
	localparam logic        CTRL_RST   = 1'b1;

	// self-timed operation state
	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_WRITE = 2'b01,
		OP_ERASE = 2'b10
	} fpp_op_e;

endpackage

// *** src/fpp_link_if.sv ***
// byte-level link between the serial shifter and the programming core
`timescale 1ns/1ps
interface fpp_link_if;
	logic       link_on;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;

	modport engine (input link_on, input tx_byte, output byte_done, output rx_byte);
	modport core   (output link_on, output tx_byte, input byte_done, input rx_byte);
endinterface

// *** src/fpp_serial_shifter.sv ***
// serial shift engine: samples the link clock and moves bytes msb first
`timescale 1ns/1ps
module fpp_serial_shifter
	import fpp_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   sck,
	input  wire logic   mosi,
	output logic        miso,
	fpp_link_if.engine  lnk
);
	logic       sck_meta;
	logic       sck_sync;
	logic       sck_prev;
	logic       mosi_meta;
	logic       mosi_sync;
	logic [2:0] bit_cnt;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       sck_rise;
	logic       sck_fall;

	// two stages before any logic looks at the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_meta  <= 1'b0;
			sck_sync  <= 1'b0;
			sck_prev  <= 1'b0;
			mosi_meta <= 1'b0;
			mosi_sync <= 1'b0;
		end else begin
			sck_meta  <= sck;
			sck_sync  <= sck_meta;
			sck_prev  <= sck_sync;
			mosi_meta <= mosi;
			mosi_sync <= mosi_meta;
		end
	end

	assign sck_rise = sck_sync & ~sck_prev;
	assign sck_fall = ~sck_sync & sck_prev;

	// receive: sample on rising edge, msb first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt   <= 3'h0;
			rx_sh     <= 8'h00;
			rx_byte   <= 8'h00;
			byte_done <= 1'b0;
		end else if (!lnk.link_on) begin
			bit_cnt   <= 3'h0;
			byte_done <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			if (sck_rise) begin
				rx_sh   <= {rx_sh[6:0], mosi_sync};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					byte_done <= 1'b1;
					rx_byte   <= {rx_sh[6:0], mosi_sync};
				end
			end
		end
	end

	// transmit: new bit after each falling edge, byte loaded at bit 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh <= 8'h00;
			miso  <= 1'b0;
		end else if (sck_fall && lnk.link_on) begin
			if (bit_cnt == 3'h0) begin
				tx_sh <= lnk.tx_byte;
				miso  <= lnk.tx_byte[7];
			end else begin
				tx_sh <= {tx_sh[6:0], 1'b0};
				miso  <= tx_sh[6];
			end
		end
	end

	assign lnk.byte_done = byte_done;
	assign lnk.rx_byte   = rx_byte;

	AST_MISO_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(miso) |-> $past(sck_fall))
		else $error("miso changed without a falling link clock edge");
	AST_BYTE_AFTER_RISE: assert property (@(posedge pclk) disable iff (!presetn)
		byte_done |-> $past(sck_rise) && $past(bit_cnt) == 3'h7)
		else $error("byte completed off the eighth rising edge");
endmodule

// *** src/fpp_flash_program_port.sv ***
// flash programming port: parallel and serial paths over a 4k code array
//
// Behaviour
// - busy pin low after strobe, high when done
// - code verify only with lock one, two clear
// - lock bits readable on data bits 2..4
// - three signature bytes at 000, 100, 200
// - serial erase is self-timed, about 500 ms
// - serial code reads return zero during erase
// - serial path works only while reset high
// - nothing but enable until enable accepted
// - erase fills the whole array with ones
// - byte-wise programming, self-timed serial write
// - serial read shifts out addressed byte
// - reset low ends programming mode
// - polling returns inverted msb during write
// - parallel byte write completes within 50 us
// - enable bytes ac 53, echo 69 last
// - erase instruction ac then 100x xxxx
// - page mode moves 256 data bytes in order
`timescale 1ns/1ps
module fpp_flash_program_port
	import fpp_pkg::*;
#(
	parameter int         ERASE_CYCLES     = ERASE_CYC,
	parameter int         SER_WRITE_CYCLES = SER_WRITE_CYC,
	parameter int         PAR_WRITE_CYCLES = PAR_WRITE_CYC,
	parameter logic [7:0] SIG_MAKER        = 8'h5a, // arbitrary value
	parameter logic [7:0] SIG_PART         = 8'ha5, // arbitrary value
	parameter logic [7:0] SIG_REV          = 8'h3c  // arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        device_reset_pin,
	input  wire logic        program_strobe,
	input  wire logic        high_voltage_enable_pin,
	input  wire logic        code_fetch_strobe,
	input  wire logic        mode_select_a,
	input  wire logic        mode_select_b,
	input  wire logic        mode_select_c,
	input  wire logic        mode_select_d,
	input  wire logic        mode_select_e,
	input  wire logic [3:0]  upper_address_nibble,
	input  wire logic [7:0]  lower_address_port,
	input  wire logic [7:0]  data_port_in,
	output logic      [7:0]  data_port_out,
	output logic             data_port_oe,
	output logic             busy_indicator_pin,
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe
);
	logic [28:0]       pin_meta;
	logic [28:0]       pin_sync;
	logic              rst_on;
	logic              strobe_s;
	logic              strobe_prev;
	logic              hv_s;
	logic              fetch_s;
	logic [4:0]        mode_s;
	logic [11:0]       addr_s;
	logic [7:0]        din_s;
	logic              par_rise;
	logic              par_rd_en;
	logic [7:0]        code_mem [0:(1<<ADDR_W)-1];
	logic [2:0]        lock;
	logic              prog_allow;
	logic              may_program;
	logic              verify_ok;
	fpp_op_e           op;
	logic [TIMER_W-1:0] timer;
	logic [12:0]       sweep;
	logic [11:0]       op_addr;
	logic [7:0]        op_data;
	logic [1:0]        byte_idx;
	logic [7:0]        cmd;
	logic [7:0]        ahi;
	logic [7:0]        alo;
	logic              enabled;
	logic              page_on;
	logic [7:0]        page_cnt;
	logic              ser_exec;
	logic              ser_write;
	logic              ser_erase;
	logic              ser_lock;
	logic              page_wr;
	logic              par_write;
	logic              par_erase;
	logic              start_write;
	logic              start_erase;
	logic [11:0]       ser_addr;
	logic [11:0]       page_addr;
	logic [7:0]        lock_byte;
	logic [7:0]        tx_byte;
	logic              par_ok;
	logic [7:0]        par_val;
	logic              hit_ctrl;
	logic              hit_status;

	fpp_link_if lnk ();

	// signature byte for an upper-address index; index 3 reads zero
	function automatic logic [7:0] sig_byte(input logic [1:0] idx);
		case (idx)
			2'h0:    sig_byte = SIG_MAKER;
			2'h1:    sig_byte = SIG_PART;
			2'h2:    sig_byte = SIG_REV;
			default: sig_byte = 8'h00;
		endcase
	endfunction

	// stored byte, or polling value while that byte is still being written
	function automatic logic [7:0] poll_read(input logic [7:0] stored, input logic hit,
		input logic [7:0] pending);
		poll_read = hit ? {~pending[7], pending[6:0]} : stored;
	endfunction

	// every pin from outside passes two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= PIN_SYNC_RST;
			pin_sync <= PIN_SYNC_RST;
		end else begin
			pin_meta <= {device_reset_pin, program_strobe, high_voltage_enable_pin,
				code_fetch_strobe, mode_select_a, mode_select_b, mode_select_c,
				mode_select_d, mode_select_e, upper_address_nibble, lower_address_port,
				data_port_in};
			pin_sync <= pin_meta;
		end
	end

	assign rst_on   = pin_sync[28];
	assign strobe_s = pin_sync[27];
	assign hv_s     = pin_sync[26];
	assign fetch_s  = pin_sync[25];
	assign mode_s   = pin_sync[24:20];
	assign addr_s   = pin_sync[19:8];
	assign din_s    = pin_sync[7:0];

	// strobe edge; action is taken when the strobe returns high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= strobe_s;
		end
	end

	assign par_rise  = strobe_s & ~strobe_prev & rst_on & hv_s & ~fetch_s;
	assign par_rd_en = rst_on & hv_s & strobe_s & ~fetch_s;

	// a programmed lock bit one blocks byte and page writes; software may also forbid them
	assign may_program = prog_allow & ~lock[0];
	assign verify_ok   = ~lock[0] & ~lock[1];
	assign lock_byte   = {3'h0, lock, 2'h0};

	// parallel requests decoded from the mode-select pattern
	assign par_write = par_rise && mode_s == PM_WRITE_CODE;
	assign par_erase = par_rise && mode_s == PM_ERASE && prog_allow;

	// serial requests complete on the fourth byte, page writes on each data byte; all need enable first
	assign ser_exec  = lnk.byte_done && !page_on && byte_idx == 2'h3 && enabled;
	assign ser_write = ser_exec && cmd == OPC_WRITE_BYTE;
	assign ser_erase = ser_exec && cmd == OPC_CTRL && ahi[7:5] == ERASE_TAG && prog_allow;
	assign ser_lock  = ser_exec && cmd == OPC_CTRL && ahi[7:2] == LOCK_TAG;
	assign ser_addr  = {ahi[3:0], alo};
	assign page_addr = {ahi[3:0], page_cnt};
	assign page_wr   = lnk.byte_done && page_on && cmd == OPC_WRITE_PAGE
		&& op == OP_IDLE && may_program;

	assign start_erase = op == OP_IDLE && (par_erase || ser_erase);
	assign start_write = op == OP_IDLE && may_program && (par_write || ser_write);

	// serial instruction framing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_idx <= 2'h0;
			cmd      <= 8'h00;
			ahi      <= 8'h00;
			alo      <= 8'h00;
			enabled  <= 1'b0;
			page_on  <= 1'b0;
			page_cnt <= 8'h00;
		end else if (!rst_on) begin
			byte_idx <= 2'h0;
			enabled  <= 1'b0;
			page_on  <= 1'b0;
		end else if (lnk.byte_done) begin
			if (page_on) begin
				page_cnt <= page_cnt + 8'h01;
				if (page_cnt == PAGE_LAST) begin
					page_on <= 1'b0;
				end
			end else begin
				case (byte_idx)
					2'h0: begin
						cmd      <= lnk.rx_byte;
						byte_idx <= 2'h1;
					end
					2'h1: begin
						ahi <= lnk.rx_byte;
						if (enabled && (cmd == OPC_READ_PAGE || cmd == OPC_WRITE_PAGE)) begin
							page_on  <= 1'b1;
							page_cnt <= 8'h00;
							byte_idx <= 2'h0;
						end else begin
							byte_idx <= 2'h2;
						end
					end
					2'h2: begin
						alo      <= lnk.rx_byte;
						byte_idx <= 2'h3;
						if (cmd == OPC_CTRL && ahi == OPC_ENABLE_2ND) begin
							enabled <= 1'b1;
						end
					end
					default: begin
						byte_idx <= 2'h0;
					end
				endcase
			end
		end
	end

	// self-timed write and erase engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op      <= OP_IDLE;
			timer   <= '0;
			sweep   <= 13'h0000;
			op_addr <= 12'h000;
			op_data <= 8'h00;
		end else begin
			case (op)
				OP_IDLE: begin
					if (start_erase) begin
						op    <= OP_ERASE;
						timer <= TIMER_W'(ERASE_CYCLES - 1);
						sweep <= 13'h0000;
					end else if (start_write) begin
						op      <= OP_WRITE;
						op_addr <= par_write ? addr_s : ser_addr;
						op_data <= par_write ? din_s : lnk.rx_byte;
						timer   <= par_write ? TIMER_W'(PAR_WRITE_CYCLES - 1)
							: TIMER_W'(SER_WRITE_CYCLES - 1);
					end
				end
				OP_WRITE: begin
					if (timer == '0) begin
						op <= OP_IDLE;
					end else begin
						timer <= timer - TIMER_W'(1);
					end
				end
				OP_ERASE: begin
					if (!sweep[12]) begin
						sweep <= sweep + 13'h0001;
					end
					if (timer != '0) begin
						timer <= timer - TIMER_W'(1);
					end else if (sweep[12]) begin
						op <= OP_IDLE;
					end
				end
				default: begin
					op <= OP_IDLE;
				end
			endcase
		end
	end

	// array writes: erase sweep, end of a timed write, page data
	always_ff @(posedge pclk) begin
		if (op == OP_ERASE && !sweep[12]) begin
			code_mem[sweep[11:0]] <= ERASED;
		end else if (op == OP_WRITE && timer == '0) begin
			code_mem[op_addr] <= op_data;
		end else if (page_wr) begin
			code_mem[page_addr] <= lnk.rx_byte;
		end
	end

	// lock bits: set one at a time, cleared when an erase completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock <= 3'h0;
		end else if (op == OP_ERASE && timer == '0 && sweep[12]) begin
			lock <= 3'h0;
		end else if (op == OP_IDLE && prog_allow) begin
			if ((par_rise && mode_s == PM_WRITE_LB1) || (ser_lock && ahi[1:0] == 2'h1)) begin
				lock[0] <= 1'b1;
			end
			if ((par_rise && mode_s == PM_WRITE_LB2) || (ser_lock && ahi[1:0] == 2'h2)) begin
				lock[1] <= 1'b1;
			end
			if ((par_rise && mode_s == PM_WRITE_LB3) || (ser_lock && ahi[1:0] == 2'h3)) begin
				lock[2] <= 1'b1;
			end
		end
	end

	// busy pin falls two cycles after the strobe starts a timed operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_indicator_pin <= 1'b1;
		end else begin
			busy_indicator_pin <= op == OP_IDLE;
		end
	end

	// parallel read value; refused reads leave the port floating
	always_comb begin
		par_ok  = 1'b0;
		par_val = 8'h00;
		case (mode_s)
			PM_READ_CODE: begin
				par_ok  = verify_ok;
				par_val = poll_read(code_mem[addr_s], op == OP_WRITE && addr_s == op_addr,
					op_data);
			end
			PM_READ_LOCK: begin
				par_ok  = 1'b1;
				par_val = lock_byte;
			end
			PM_READ_SIG: begin
				par_ok  = ~lock[1] && addr_s[11:10] == 2'h0 && addr_s[7:0] == 8'h00;
				par_val = sig_byte(addr_s[9:8]);
			end
			default: begin
				par_ok  = 1'b0;
				par_val = 8'h00;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_port_oe  <= 1'b0;
			data_port_out <= 8'h00;
		end else begin
			data_port_oe  <= par_rd_en && par_ok;
			data_port_out <= par_val;
		end
	end

	// serial answer byte for the next byte slot on the link
	always_comb begin
		tx_byte = 8'h00;
		if (page_on) begin
			if (cmd == OPC_READ_PAGE && verify_ok && op != OP_ERASE) begin
				tx_byte = code_mem[page_addr];
			end
		end else if (byte_idx == 2'h3 && cmd == OPC_CTRL && ahi == OPC_ENABLE_2ND) begin
			tx_byte = enabled ? ENABLE_ECHO : 8'h00;
		end else if (byte_idx == 2'h3 && enabled) begin
			case (cmd)
				OPC_READ_BYTE: begin
					if (op == OP_ERASE) begin
						tx_byte = 8'h00;
					end else if (verify_ok) begin
						tx_byte = poll_read(code_mem[ser_addr],
							op == OP_WRITE && ser_addr == op_addr, op_data);
					end
				end
				OPC_READ_LOCK: tx_byte = lock_byte;
				OPC_READ_SIG: begin
					if (!lock[1] && ahi[3:2] == 2'h0) begin
						tx_byte = sig_byte(ahi[1:0]);
					end
				end
				default: tx_byte = 8'h00;
			endcase
		end
	end

	assign lnk.link_on = rst_on;
	assign lnk.tx_byte = tx_byte;
	assign miso_oe     = rst_on;

	fpp_serial_shifter u_shifter (
		.pclk    (pclk),
		.presetn (presetn),
		.sck     (sck),
		.mosi    (mosi),
		.miso    (miso),
		.lnk     (lnk.engine)
	);

	// register bus: zero wait states, data prepared in the setup phase
	assign hit_ctrl   = paddr == CTRL_OFF;
	assign hit_status = paddr == STATUS_OFF;
	assign pready     = 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_allow <= CTRL_RST;
		end else if (psel && penable && pwrite && hit_ctrl) begin
			prog_allow <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !(hit_ctrl || hit_status);
			if (hit_ctrl) begin
				prdata <= {31'h00000000, prog_allow};
			end else if (hit_status) begin
				prdata <= {25'h0000000, lock, rst_on, enabled, op == OP_ERASE, op != OP_IDLE};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	AST_BUSY_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		par_write && start_write |=> ##1 !busy_indicator_pin)
		else $error("busy pin not low after a parallel write strobe");
	AST_BUSY_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(op != OP_IDLE) |=> busy_indicator_pin)
		else $error("busy pin not released after the write");
	AST_VERIFY_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		(lock[1:0] != 2'h0 && mode_s == PM_READ_CODE) |=> !data_port_oe)
		else $error("code verify driven while locked");
	AST_LOCK_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(par_rd_en && mode_s == PM_READ_LOCK) |=> data_port_oe
			&& data_port_out[4:2] == $past(lock))
		else $error("lock bits not on data bits 4:2");
	AST_SIGNATURE: assert property (@(posedge pclk) disable iff (!presetn)
		(par_rd_en && mode_s == PM_READ_SIG && !lock[1] && addr_s == 12'h100)
			|=> data_port_oe && data_port_out == SIG_PART)
		else $error("wrong signature byte at 100");
	AST_ERASE_TIME: assert property (@(posedge pclk) disable iff (!presetn)
		start_erase |=> op == OP_ERASE && timer == TIMER_W'(ERASE_CYCLES - 1))
		else $error("erase did not start its full timer");
	AST_ERASE_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_ERASE && !page_on && byte_idx == 2'h3 && cmd == OPC_READ_BYTE)
			|-> tx_byte == 8'h00)
		else $error("serial read during erase not zero");
	AST_IGNORE_UNTIL_ENABLED: assert property (@(posedge pclk) disable iff (!presetn)
		(!enabled && op == OP_IDLE && !par_rise) |=> op == OP_IDLE)
		else $error("serial operation ran before enable");
	AST_RESET_LOW_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_on |=> !enabled && !page_on && byte_idx == 2'h0)
		else $error("programming mode kept after reset low");
	AST_POLL_MSB: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_WRITE && enabled && verify_ok && !page_on && byte_idx == 2'h3
			&& cmd == OPC_READ_BYTE && ser_addr == op_addr) |-> tx_byte[7] == !op_data[7])
		else $error("polling msb not inverted during write");
endmodule

// *** verification/fpp_isp_host.sv ***
// serial programming host model for the flash programming port
`timescale 1ns/1ps
module fpp_isp_host (
	input  wire logic pclk,
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	// link clock idles low outside frames
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
	end
	// one 4-byte frame, msb first; the answer is the last byte seen on miso
	task automatic xfer(input logic [31:0] cmd, output logic [7:0] rsp);
		logic [31:0] got;
		got = '0;
		for (int i = 31; i >= 0; i--) begin
			@(posedge pclk) mosi <= cmd[i];
			repeat (11) @(posedge pclk);
			sck <= 1'b1;
			repeat (13) @(posedge pclk);
			got = {got[30:0], miso};
			sck <= 1'b0;
		end
		@(posedge pclk) mosi <= ~mosi; // no stale bit left on the line
		rsp = got[7:0];
	endtask
endmodule

// *** verification/flash_program_port_tb.sv ***
// self-checking bench for the flash programming port
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_program_port_tb;
	import fpp_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        rst_pin = 0, strobe = 1, hv = 0, pready, pslverr, err;
	logic        oe, busy, sck, mosi, miso, miso_oe;
	logic [4:0]  ms = '0;
	logic [11:0] paddr = '0, addr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [7:0]  din = '0, dout, b;
	localparam logic [23:0] SIGS = 24'h654321; // arbitrary values, one byte per signature
	int          mismatches = 0, total_checks = 0;
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	fpp_flash_program_port #(.ERASE_CYCLES(5000), .SER_WRITE_CYCLES(2000),
		.PAR_WRITE_CYCLES(20), .SIG_MAKER(SIGS[7:0]), .SIG_PART(SIGS[15:8]),
		.SIG_REV(SIGS[23:16]))
	fpp_flash_program_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .device_reset_pin(rst_pin),
		.program_strobe(strobe), .high_voltage_enable_pin(hv), .code_fetch_strobe(1'b0),
		.mode_select_a(ms[4]), .mode_select_b(ms[3]), .mode_select_c(ms[2]),
		.mode_select_d(ms[1]), .mode_select_e(ms[0]), .upper_address_nibble(addr[11:8]),
		.lower_address_port(addr[7:0]), .data_port_in(din), .data_port_out(dout),
		.data_port_oe(oe), .busy_indicator_pin(busy), .sck(sck), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe));
	fpp_isp_host fpp_isp_host_inst (.pclk(pclk), .sck(sck), .mosi(mosi), .miso(miso));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// apb transfer: request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			give_verdict();
		end
	endtask
	// bounded wait for the ready level on the busy pin
	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (busy !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (n >= lim) begin
			mismatches++;
			give_verdict();
		end
	endtask
	// parallel access: k 0 read, 1 pulse, 2 pulse and expect busy
	task automatic par(input logic [4:0] m, input logic [11:0] a, input logic [7:0] d, input int k);
		@(posedge pclk);
		ms <= m;
		addr <= a;
		din <= d;
		hv <= 1'b1;
		repeat (50) @(posedge pclk);
		if (k > 0) begin
			strobe <= 1'b0;
			repeat (60) @(posedge pclk);
			strobe <= 1'b1;
			repeat (6) @(posedge pclk);
			if (k == 2) `CHK(busy, 1'b0)
			wait_ready(6000);
			repeat (50) @(posedge pclk);
		end
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFF, '0);
		`CHK(rd, 32'h1)
		`CHK(pready, 1'b1)
		apb(1'b1, CTRL_OFF, 32'h0);
		apb(1'b0, CTRL_OFF, '0);
		`CHK(rd, 32'h0)
		apb(1'b1, CTRL_OFF, 32'h1);
		apb(1'b0, 12'h008, '0);
		`CHK(err, 1'b1)
		$display("test registers done");
		rst_pin <= 1'b1;
		repeat (100) @(posedge pclk);
		fpp_isp_host_inst.xfer(32'h2001_2300, b);
		`CHK(b, 8'h00)
		fpp_isp_host_inst.xfer({OPC_CTRL, OPC_ENABLE_2ND, 16'h0}, b);
		`CHK(b, ENABLE_ECHO)
		apb(1'b0, STATUS_OFF, '0);
		`CHK(rd[3:2], 2'b11)
		fpp_isp_host_inst.xfer(32'hac80_0000, b);
		fpp_isp_host_inst.xfer(32'h200f_ff00, b);
		`CHK(b, 8'h00)
		wait_ready(6000);
		fpp_isp_host_inst.xfer(32'h200f_ff00, b);
		`CHK(b, ERASED)
		fpp_isp_host_inst.xfer(32'h4001_235a, b);
		fpp_isp_host_inst.xfer(32'h2001_2300, b);
		`CHK(b, 8'hda)
		wait_ready(3000);
		fpp_isp_host_inst.xfer(32'h2001_2300, b);
		`CHK(b, 8'h5a)
		fpp_isp_host_inst.xfer(32'h2802_0000, b);
		`CHK(b, SIGS[23:16])
		$display("test serial done");
		par(PM_WRITE_CODE, 12'h345, 8'hc3, 2);
		par(PM_READ_CODE, 12'h345, 8'h00, 0);
		`CHK({oe, dout}, 9'h1c3)
		for (int i = 0; i < 3; i++) begin
			par(PM_READ_SIG, 12'(i * 256), 8'h00, 0);
			`CHK(dout, SIGS[i*8 +: 8])
		end
		par(PM_READ_LOCK, 12'h000, 8'h00, 0);
		`CHK(dout, 8'h00)
		par(PM_WRITE_LB1, 12'h000, 8'h00, 1);
		par(PM_READ_LOCK, 12'h000, 8'h00, 0);
		`CHK(dout, 8'h04)
		par(PM_READ_CODE, 12'h345, 8'h00, 0);
		`CHK(oe, 1'b0)
		par(PM_ERASE, 12'h000, 8'h00, 2);
		par(PM_READ_CODE, 12'h345, 8'h00, 0);
		`CHK(dout, ERASED)
		$display("test parallel done");
		fpp_isp_host_inst.xfer(32'hace1_0000, b);
		fpp_isp_host_inst.xfer(32'h2400_0000, b);
		`CHK(b, 8'h04)
		rst_pin <= 1'b0;
		repeat (5) @(posedge pclk);
		`CHK(miso_oe, 1'b0)
		rst_pin <= 1'b1;
		repeat (100) @(posedge pclk);
		fpp_isp_host_inst.xfer(32'h2001_2300, b);
		`CHK(b, 8'h00)
		$display("test session end done");
		give_verdict();
	end
endmodule
